// [rtl/dpg_pkg.sv]
package dpg_pkg;

  // ****************************************************************
  // Register map (word index = byte address / 4 not used: plain port)
  // ****************************************************************
  localparam logic [3:0] ADDR_GEN0_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_GEN1_CTRL  = 4'h1;
  localparam logic [3:0] ADDR_MAP        = 4'h2;
  localparam logic [3:0] ADDR_ENABLE     = 4'h3;
  localparam logic [3:0] ADDR_TRIM       = 4'h4;
  localparam logic [3:0] ADDR_STATUS     = 4'h5;
  localparam logic [3:0] ADDR_PAR_MAP    = 4'h6;

  // ****************************************************************
  // Control word fields
  // ****************************************************************
  localparam int DUTY_LSB   = 0;
  localparam int DUTY_W     = 8;
  localparam int PSEL_LSB   = 8;
  localparam int PSEL_W     = 2;

  // ****************************************************************
  // Period selector encodings
  // ****************************************************************
  localparam logic [1:0] PSEL_DIV1024 = 2'h0;
  localparam logic [1:0] PSEL_DIV512  = 2'h1;
  localparam logic [1:0] PSEL_DIV256  = 2'h2;
  localparam logic [1:0] PSEL_ALWAYS  = 2'h3;

  // Base ticks per duty step, less one, for each divider (256 steps per period)
  localparam logic [1:0] STEP_DIV1024 = 2'h3;
  localparam logic [1:0] STEP_DIV512  = 2'h1;
  localparam logic [1:0] STEP_DIV256  = 2'h0;

  // ****************************************************************
  // Reset values and oscillator trim
  // ****************************************************************
  localparam logic [7:0] DUTY_RST     = 8'h00;
  localparam logic [1:0] PSEL_RST     = 2'h0;
  localparam logic [3:0] TRIM_NOMINAL = 4'h8;
  localparam logic [3:0] TRIM_RSVD    = 4'h0;
  localparam logic [7:0] ROUTE_RST    = 8'h00;

  // Core clock and nominal base tick
  localparam int CORE_CLK_HZ   = 20_000_000;
  localparam int BASE_TICK_HZ  = 102_400;
  localparam int NOM_TICK_CYC  = CORE_CLK_HZ / BASE_TICK_HZ;

endpackage : dpg_pkg

// [rtl/dpg_gen.sv]
`timescale 1ns/1ps
module dpg_gen
(
  input  wire logic       core_clk_i,   // Core clock
  input  wire logic       rst_n_i,      // Async reset, active low
  input  wire logic       tick_i,       // Base tick pulse
  input  wire logic [7:0] duty_i,       // Software duty value
  input  wire logic [1:0] psel_i,       // Software period selector
  output logic            pwm_o,        // Generator output
  output logic            start_o       // Period start pulse
);
  logic [7:0] duty_reg;
  logic [1:0] psel_reg;
  logic [7:0] step_reg;
  logic [1:0] sub_reg;
  logic [1:0] sub_max;
  logic       step_end;
  logic       per_end;

  always_comb
  begin
    unique case (psel_reg)
      dpg_pkg::PSEL_DIV1024: sub_max = dpg_pkg::STEP_DIV1024;
      dpg_pkg::PSEL_DIV512:  sub_max = dpg_pkg::STEP_DIV512;
      dpg_pkg::PSEL_DIV256:  sub_max = dpg_pkg::STEP_DIV256;
      dpg_pkg::PSEL_ALWAYS:  sub_max = dpg_pkg::STEP_DIV256;
    endcase
  end

  assign step_end = tick_i && (sub_reg == sub_max);
  assign per_end  = step_end && (step_reg == 8'hff);

  // ****************************************************************
  // Step counter: 256 steps per period
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sub_reg  <= 2'h0;
      step_reg <= 8'h00;
    end
    else if (tick_i)
    begin
      sub_reg <= (sub_reg == sub_max) ? 2'h0 : sub_reg + 2'h1;
      if (step_end)
        step_reg <= step_reg + 8'h01;
    end
  end

  // Settings latched only at a period boundary; no runt periods
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      duty_reg <= dpg_pkg::DUTY_RST;
      psel_reg <= dpg_pkg::PSEL_RST;
    end
    else if (per_end)
    begin
      duty_reg <= duty_i;
      psel_reg <= psel_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pwm_o   <= 1'b0;
      start_o <= 1'b0;
    end
    else
    begin
      // Duty ff gives 255 of 256 steps; selector 11 forces on
      pwm_o   <= (psel_reg == dpg_pkg::PSEL_ALWAYS) ||
                 (step_reg < duty_reg);
      start_o <= per_end;
    end
  end
endmodule : dpg_gen

// [rtl/dpg_top.sv]
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - Eight-bit duty value, 1/256 period steps
// - New duty applied from next period start
// - Deferral also holds at fully off/on
// - Duty all ones gives 255/256 on
// - Period selector 11 forces output on
// - Two-bit selector picks base tick divider
// - Dividers 1024, 512, 256 for 00/01/10
// - Channels routable to either generator
// - Generators plus inputs give four groups
// - Two independent generators, own settings
// - Base tick trimmed by four-bit code
module dpg_top
#(
  parameter int NCH      = 8,                     // Number of output channels
  parameter int TICK_CYC = dpg_pkg::NOM_TICK_CYC  // Core cycles per tick, nominal trim
)(
  input  wire logic           core_clk_i,   // Core clock, 20 MHz
  input  wire logic           rst_n_i,      // Async reset, active low
  input  wire logic [3:0]     addr_i,       // Register word address
  input  wire logic [15:0]    wdata_i,      // Write data
  input  wire logic           wr_i,         // Write strobe
  input  wire logic           rd_i,         // Read strobe
  input  wire logic [1:0]     parallel_input_i, // Parallel input pins
  output logic [15:0]         rdata_o,      // Read data, cycle after rd_i
  output logic [NCH-1:0]      chan_o,       // Routed channel drive
  output logic [1:0]          pwm_o,        // Raw generator outputs
  output logic                tick_o        // Base tick pulse
);
  // ****************************************************************
  // Software registers
  // ****************************************************************
  logic [7:0]     duty_value_reg [2];
  logic [1:0]     period_select_reg [2];
  logic [NCH-1:0] gen_map_reg;     // 0: generator 0, 1: generator 1
  logic [NCH-1:0] gen_en_reg;      // Channel follows its generator
  logic [NCH-1:0] par_en_reg;      // Channel follows a parallel input
  logic [NCH-1:0] par_map_reg;     // 0: input 0, 1: input 1
  logic [3:0]     base_osc_trim_reg;
  logic [1:0]     start_seen_reg;
  logic [1:0]     gen_out;
  logic [1:0]     gen_start;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      duty_value_reg[0]    <= dpg_pkg::DUTY_RST;
      duty_value_reg[1]    <= dpg_pkg::DUTY_RST;
      period_select_reg[0] <= dpg_pkg::PSEL_RST;
      period_select_reg[1] <= dpg_pkg::PSEL_RST;
      gen_map_reg          <= '0;
      gen_en_reg           <= '0;
      par_en_reg           <= '0;
      par_map_reg          <= '0;
      base_osc_trim_reg    <= dpg_pkg::TRIM_NOMINAL;
    end
    else if (wr_i)
    begin
      unique case (addr_i)
        dpg_pkg::ADDR_GEN0_CTRL:
        begin
          duty_value_reg[0]    <= wdata_i[dpg_pkg::DUTY_LSB +: dpg_pkg::DUTY_W];
          period_select_reg[0] <= wdata_i[dpg_pkg::PSEL_LSB +: dpg_pkg::PSEL_W];
        end
        dpg_pkg::ADDR_GEN1_CTRL:
        begin
          duty_value_reg[1]    <= wdata_i[dpg_pkg::DUTY_LSB +: dpg_pkg::DUTY_W];
          period_select_reg[1] <= wdata_i[dpg_pkg::PSEL_LSB +: dpg_pkg::PSEL_W];
        end
        dpg_pkg::ADDR_MAP:
        begin
          gen_map_reg <= wdata_i[NCH-1:0];
          par_map_reg <= wdata_i[8 +: NCH];
        end
        dpg_pkg::ADDR_ENABLE:
        begin
          gen_en_reg <= wdata_i[NCH-1:0];
          par_en_reg <= wdata_i[8 +: NCH];
        end
        dpg_pkg::ADDR_TRIM:
          // Reserved code is refused; the old trim stays
          if (wdata_i[3:0] != dpg_pkg::TRIM_RSVD)
            base_osc_trim_reg <= wdata_i[3:0];
        default:
        begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Base tick: stands in for the trimmed internal oscillator
  // ****************************************************************
  // Period in core cycles scales with 8/trim; coarse but monotonic,
  // exact at codes 1, 2, 4 and the nominal 8.
  logic [15:0] tick_cnt_reg;
  logic [15:0] tick_len;
  assign tick_len = 16'((TICK_CYC * int'(dpg_pkg::TRIM_NOMINAL))
                        / int'(base_osc_trim_reg));

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tick_cnt_reg <= 16'h0000;
      tick_o       <= 1'b0;
    end
    else if (tick_cnt_reg + 16'h0001 >= tick_len)
    begin
      tick_cnt_reg <= 16'h0000;
      tick_o       <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      tick_o       <= 1'b0;
    end
  end

  // ****************************************************************
  // Generators
  // ****************************************************************
  for (genvar g = 0; g < 2; g++)
  begin : g_gen
    dpg_gen u_gen (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .tick_i     (tick_o),
      .duty_i     (duty_value_reg[g]),
      .psel_i     (period_select_reg[g]),
      .pwm_o      (gen_out[g]),
      .start_o    (gen_start[g])
    );
  end

  // ****************************************************************
  // Channel routing and status
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      chan_o <= '0;
      pwm_o  <= 2'h0;
    end
    else
    begin
      pwm_o <= gen_out;
      for (int c = 0; c < NCH; c++)
        chan_o[c] <= (gen_en_reg[c] && gen_out[gen_map_reg[c]]) ||
                     (par_en_reg[c] && parallel_input_i[par_map_reg[c]]);
    end
  end

  // Sticky period-start flags; cleared by reading status, set wins
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      start_seen_reg <= 2'h0;
    else if (rd_i && addr_i == dpg_pkg::ADDR_STATUS)
      start_seen_reg <= gen_start;
    else
      start_seen_reg <= start_seen_reg | gen_start;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= 16'h0000;
    else if (rd_i)
    begin
      unique case (addr_i)
        dpg_pkg::ADDR_GEN0_CTRL: rdata_o <= {6'h00, period_select_reg[0], duty_value_reg[0]};
        dpg_pkg::ADDR_GEN1_CTRL: rdata_o <= {6'h00, period_select_reg[1], duty_value_reg[1]};
        dpg_pkg::ADDR_MAP:       rdata_o <= 16'({par_map_reg, 8'h00} | 16'(gen_map_reg));
        dpg_pkg::ADDR_ENABLE:    rdata_o <= 16'({par_en_reg, 8'h00} | 16'(gen_en_reg));
        dpg_pkg::ADDR_TRIM:      rdata_o <= {12'h000, base_osc_trim_reg};
        dpg_pkg::ADDR_STATUS:    rdata_o <= {12'h000, start_seen_reg, gen_out};
        default:                 rdata_o <= 16'h0000;
      endcase
    end
    else
      rdata_o <= 16'h0000;
  end
endmodule : dpg_top

// [dv/dpg_assertions.sv]
`timescale 1ns/1ps
module dpg_assertions #(
  parameter int NCH      = 8,                        // Channel count
  parameter int TICK_CYC = dpg_pkg::NOM_TICK_CYC     // Core cycles per nominal tick
)(
  input  wire logic           core_clk_i,           // Core clock
  input  wire logic           rst_n_i,              // Async reset
  input  wire logic [3:0]     addr_i,               // Word address
  input  wire logic [15:0]    wdata_i,              // Write data
  input  wire logic           wr_i,                 // Write strobe
  input  wire logic           rd_i,                 // Read strobe
  input  wire logic [1:0]     parallel_input_i,     // Parallel pins
  input  wire logic [15:0]    rdata_o,              // Read data
  input  wire logic [NCH-1:0] chan_o,               // Channel drive
  input  wire logic [1:0]     pwm_o,                // Generator outputs
  input  wire logic           tick_o                // Base tick
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ****************************************************************
  // Shadow of the setup written by software
  // ****************************************************************
  logic [15:0]    map_reg;
  logic [15:0]    en_reg;
  logic [3:0]     trim_reg;
  logic [11:0]    gap_reg;
  logic           armed_reg;
  logic [NCH-1:0] route_w;
  always_ff @(posedge core_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      map_reg  <= 16'h0000;
      en_reg   <= 16'h0000;
      trim_reg <= 4'h8;
    end
    else if (wr_i)
    begin
      if (addr_i == dpg_pkg::ADDR_MAP) map_reg <= wdata_i;
      if (addr_i == dpg_pkg::ADDR_ENABLE) en_reg <= wdata_i;
      if (addr_i == dpg_pkg::ADDR_TRIM && wdata_i[3:0] != 4'h0) trim_reg <= wdata_i[3:0];
    end
  // Only a gap that began after the last trim write is judged
  always_ff @(posedge core_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      gap_reg   <= 12'h000;
      armed_reg <= 1'b0;
    end
    else
    begin
      gap_reg   <= tick_o ? 12'h000 : gap_reg + 12'h001;
      armed_reg <= (wr_i && addr_i == dpg_pkg::ADDR_TRIM) ? 1'b0 : (tick_o | armed_reg);
    end
  always_comb
    for (int i = 0; i < NCH; i++) route_w[i] = en_reg[i] & pwm_o[map_reg[i]];

  AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data not zero outside its slot");
  AST_UNMAPPED: assert property ($past(rd_i) && $past(addr_i) > dpg_pkg::ADDR_PAR_MAP
    |-> rdata_o == 16'h0000) else $error("unmapped read not zero");
  AST_TRIM_READ: assert property ($past(rd_i) && $past(addr_i) == dpg_pkg::ADDR_TRIM
    |-> rdata_o == {12'h000, $past(trim_reg)}) else $error("trim read back wrong");
  AST_TICK_PULSE: assert property (tick_o |=> !tick_o) else $error("tick longer than one cycle");
  AST_TICK_SPACING: assert property (tick_o && armed_reg
    |-> int'(gap_reg) + 1 == TICK_CYC * 8 / int'(trim_reg)) else $error("tick gap");
  AST_CHAN_ROUTE: assert property (en_reg[15:8] == 8'h00 && !$past(wr_i)
    |-> chan_o == route_w) else $error("channel does not follow its generator");
  AST_PWM_STEP: assert property ($changed(pwm_o[0]) |=> $stable(pwm_o[0]) [*8])
    else $error("generator output shorter than one step");
  AST_STATUS_LIVE: assert property ($past(rd_i) && $past(addr_i) == dpg_pkg::ADDR_STATUS
    && $stable(pwm_o) && $past(pwm_o, 2) == $past(pwm_o) |-> rdata_o[1:0] == pwm_o)
    else $error("status does not show generator outputs");
endmodule : dpg_assertions

bind dpg_top dpg_assertions #(.NCH(NCH), .TICK_CYC(TICK_CYC)) u_chk (.core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .parallel_input_i(parallel_input_i), .rdata_o(rdata_o), .chan_o(chan_o), .pwm_o(pwm_o),
  .tick_o(tick_o));

// [dv/test_dual_channel_pwm_generator.sv]
`timescale 1ns/1ps
module test_dual_channel_pwm_generator;
  // Short base tick keeps a select-00 period well inside the run budget
  localparam int TICK = 40;
  // One step at select 10 is one tick; trim 15 gives 320/15 cycles a tick
  localparam int STEP = TICK * 8 / 15;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [1:0]  parallel_input_i = 2'h0;
  logic [15:0] rdata_o;
  logic [7:0]  chan_o;
  logic [1:0]  pwm_o;
  logic        tick_o;
  logic [15:0] d;
  int          n;
  int          miscompares = 0;
  int          tests_run = 0;
  always #25 core_clk_i = ~core_clk_i;
  dpg_top #(.NCH(8), .TICK_CYC(TICK)) DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .parallel_input_i(parallel_input_i),
    .rdata_o(rdata_o), .chan_o(chan_o), .pwm_o(pwm_o), .tick_o(tick_o));

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  // Bounded wait until bit sel of {tick, pwm} reaches lvl; n counts edges
  task automatic span(input int sel, input logic lvl);
    logic [2:0] s;
    n = 0;
    s = {tick_o, pwm_o};
    while (s[sel] !== lvl && n < 50000)
    begin
      @(posedge core_clk_i);
      #1 n++;
      s = {tick_o, pwm_o};
    end
  endtask : span
  task automatic end_of_test();
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    rd(dpg_pkg::ADDR_GEN0_CTRL);
    check("gen0 ctrl", d, 32'h0);
    wr(dpg_pkg::ADDR_TRIM, 16'h0000);
    rd(dpg_pkg::ADDR_TRIM);
    check("trim", d, 32'h8);
    wr(dpg_pkg::ADDR_TRIM, 16'h000f);
    rd(dpg_pkg::ADDR_TRIM);
    check("trim", d, 32'hf);
    rd(4'hf);
    check("unmapped", d, 32'h0);
  endtask : t_regs
  task automatic t_tick();
    span(2, 1);
    span(2, 0);
    span(2, 1);
    check("tick gap", n + 1, STEP);
  endtask : t_tick
  // Generators start with select 00, so the first boundary is a long way off
  task automatic t_pwm();
    wr(dpg_pkg::ADDR_GEN0_CTRL, 16'h0280);
    wr(dpg_pkg::ADDR_GEN1_CTRL, 16'h0300);
    wr(dpg_pkg::ADDR_MAP, 16'h0002);
    wr(dpg_pkg::ADDR_ENABLE, 16'h0003);
    span(0, 1);
    check("late start", n > 1000 * STEP, 32'h1);
    wr(dpg_pkg::ADDR_GEN0_CTRL, 16'h0240);
    wr(dpg_pkg::ADDR_GEN1_CTRL, 16'h02ff);
    span(0, 0);
    check("old high", n + 4, 128 * STEP);
    check("gen1 on", pwm_o[1], 32'h1);
    check("chan1", chan_o[1], 32'h1);
    span(0, 1);
    check("low", n, 128 * STEP);
    span(0, 0);
    check("new high", n, 64 * STEP);
    span(1, 0);
    check("full high", n + 64 * STEP, 255 * STEP);
    span(1, 1);
    check("full low", n, STEP);
    rd(dpg_pkg::ADDR_STATUS);
    check("status", d[1:0], 32'h3);
    check("starts seen", d[3:2], 32'h3);
    rd(dpg_pkg::ADDR_STATUS);
    check("starts cleared", d[3:2], 32'h0);
  endtask : t_pwm
  task automatic t_par();
    wr(dpg_pkg::ADDR_MAP, 16'h0400);
    wr(dpg_pkg::ADDR_ENABLE, 16'h0400);
    parallel_input_i <= 2'h2;
    repeat (4) @(posedge core_clk_i);
    #1 check("par on", chan_o, 32'h4);
    parallel_input_i <= 2'h1;
    repeat (4) @(posedge core_clk_i);
    #1 check("par off", chan_o, 32'h0);
  endtask : t_par

  initial
  begin
    repeat (20) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_tick();
    t_pwm();
    t_par();
    end_of_test();
  end
  // Whole run needs about 32k cycles
  initial
  begin
    repeat (60000) @(posedge core_clk_i);
    miscompares++;
    end_of_test();
  end
endmodule : test_dual_channel_pwm_generator
